// ==== src/dq_regs.sv ====
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "dq_defines.svh"
module dq_regs (
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic           trigger_source_jumper,
  input  wire logic           external_trigger_input,
  input  wire logic           pacer_out,
  input  wire logic [7:0]     timer_rdata,
  output dq_pkg::dq_tmr_req_t timer_req,
  output logic                adc_start,
  input  wire logic [11:0]    adc_data,
  output logic                irq,
  output logic                dma_req,
  input  wire logic           dma_ack,
  input  wire logic [15:0]    din_lines,
  output logic [15:0]         dout_lines,
  output logic [11:0]         aout1_code,
  output logic [11:0]         aout2_code
);
  localparam int CONV_LIM = 800;

  dq_pkg::dq_state_t s_ff;
  dq_pkg::dq_state_t nxt_s;
  logic              take;
  logic              wr;
  logic              rd;
  logic              mapped;
  logic [5:0]        idx;
  logic [7:0]        rbyte;
  logic              soft_en;
  logic              pacer_en;
  logic              ext_edge;
  logic              pacer_edge;
  logic              soft_wr;
  logic              trig;
  logic              conv_end;

  // ==========================================
  // apb decode
  // one wait state on every access, two on timer reads, keeps all bus outputs registered
  assign take = psel & penable & ~s_ff.apb.pready & ~s_ff.tmr_wait;
  assign idx  = paddr[7:2];
  assign wr   = take & pwrite & mapped;
  assign rd   = take & ~pwrite & mapped;

  // read mux and address map
  always_comb begin
    mapped = 1'b1;
    rbyte  = 8'h00;
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (idx <= `DQ_IDX_TCTL) begin
      rbyte = timer_rdata;
    end else if (idx == `DQ_IDX_AO1L || idx == `DQ_IDX_AO1H) begin
      rbyte = 8'h00;
    end else if (idx == `DQ_IDX_AO2L) begin
      rbyte = din_lines[7:0];
    end else if (idx == `DQ_IDX_AO2H) begin
      rbyte = din_lines[15:8];
    end else if (idx == `DQ_IDX_INTCLR || idx == `DQ_IDX_OPMODE) begin
      rbyte = 8'h00;
    end else if (idx == `DQ_IDX_SOFT || idx == `DQ_IDX_DOUTL) begin
      rbyte = 8'h00;
    end else if (idx == `DQ_IDX_DOUTH) begin
      rbyte = 8'h00;
    end else if (idx == `DQ_IDX_ADL) begin
      rbyte = s_ff.adc_result[7:0];
    end else if (idx == `DQ_IDX_ADH) begin
      rbyte[3:0] = s_ff.adc_result[11:8];
      rbyte[`DQ_ADH_FLAG_BIT] = s_ff.done_flag;
    end else begin
      mapped = 1'b0;
    end
  end

  // ==========================================
  // trigger selection
  // the jumper overrides the mode register; internal sources go quiet
  assign soft_en  = ~trigger_source_jumper
                  & (s_ff.op_mode == `DQ_MODE_SOFT);
  assign pacer_en = ~trigger_source_jumper
                  & ((s_ff.op_mode == `DQ_MODE_PDMA)
                  | (s_ff.op_mode == `DQ_MODE_PINT));
  // edge taken from the second stage only, never the first
  assign ext_edge   = s_ff.ext_sync2 & ~s_ff.ext_prev;
  assign pacer_edge = pacer_out & ~s_ff.pacer_prev;
  assign soft_wr    = wr & (idx == `DQ_IDX_SOFT);
  assign trig = (trigger_source_jumper & ext_edge)
              | (pacer_en & pacer_edge)
              | (soft_en & soft_wr);
  assign conv_end = (s_ff.conv_st == dq_pkg::DQ_ST_CONV)
                  & (s_ff.conv_cnt == `DQ_CONV_CYC - 10'h001);

  // ==========================================
  // next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.apb.pready  = 1'b0;
    nxt_s.apb.pslverr = 1'b0;
    nxt_s.apb.prdata  = 32'h0000_0000;
    nxt_s.tmr.wr      = 1'b0;
    nxt_s.tmr.rd      = 1'b0;
    nxt_s.tmr_wait    = 1'b0;
    nxt_s.adc_start   = 1'b0;

    // bus answer; timer reads wait one more cycle for its data
    if (s_ff.tmr_wait) begin
      nxt_s.apb.pready = 1'b1;
      nxt_s.apb.prdata = {24'h00_0000, timer_rdata};
    end else if (take && !mapped) begin
      nxt_s.apb.pready  = 1'b1;
      nxt_s.apb.pslverr = 1'b1;
    end else if (rd && idx <= `DQ_IDX_TCTL) begin
      nxt_s.tmr.rd   = 1'b1;
      nxt_s.tmr.idx  = idx[1:0];
      nxt_s.tmr_wait = 1'b1;
    end else if (take) begin
      nxt_s.apb.pready = 1'b1;
      nxt_s.apb.prdata = {24'h00_0000, pwrite ? 8'h00 : rbyte};
    end

    // register writes
    if (wr) begin
      if (idx <= `DQ_IDX_TCTL) begin
        nxt_s.tmr.wr    = 1'b1;
        nxt_s.tmr.idx   = idx[1:0];
        nxt_s.tmr.wdata = pwdata[7:0];
      end else if (idx == `DQ_IDX_OPMODE) begin
        nxt_s.op_mode = pwdata[2:0];
      end else if (idx == `DQ_IDX_DOUTL) begin
        nxt_s.dout[7:0] = pwdata[7:0];
      end else if (idx == `DQ_IDX_DOUTH) begin
        nxt_s.dout[15:8] = pwdata[7:0];
      end
    end

    // input edge history
    nxt_s.ext_sync1  = external_trigger_input;
    nxt_s.ext_sync2  = s_ff.ext_sync1;
    nxt_s.ext_prev   = s_ff.ext_sync2;
    nxt_s.pacer_prev = pacer_out;

    // conversion sequencer
    case (s_ff.conv_st)
      dq_pkg::DQ_ST_IDLE: begin
        if (trig) begin
          nxt_s.conv_st   = dq_pkg::DQ_ST_CONV;
          nxt_s.conv_cnt  = 10'h000;
          nxt_s.adc_start = 1'b1;
          nxt_s.done_flag = 1'b0;
        end
      end
      dq_pkg::DQ_ST_CONV: begin
        // triggers here are dropped, not restarted
        nxt_s.conv_cnt = s_ff.conv_cnt + 10'h001;
        if (conv_end) begin
          nxt_s.conv_st    = dq_pkg::DQ_ST_IDLE;
          nxt_s.adc_result = adc_data;
        end
      end
      default: begin
        nxt_s.conv_st = dq_pkg::DQ_ST_IDLE;
      end
    endcase

    // done flag: consuming read clears, a finishing conversion wins
    if (rd && idx == `DQ_IDX_ADL) begin
      nxt_s.done_flag = 1'b0;
    end
    if (conv_end) begin
      nxt_s.done_flag = 1'b1;
    end

    // interrupt status: held until any write to the clear index
    if (wr && idx == `DQ_IDX_INTCLR) begin
      nxt_s.int_status = 1'b0;
    end
    if (conv_end && s_ff.op_mode == `DQ_MODE_PINT) begin
      nxt_s.int_status = 1'b1;
    end

    // dma request: dropped by the controller's acknowledge
    if (dma_ack) begin
      nxt_s.dma_req = 1'b0;
    end
    if (conv_end && s_ff.op_mode == `DQ_MODE_PDMA) begin
      nxt_s.dma_req = 1'b1;
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff         <= '0;
      s_ff.op_mode <= `DQ_MODE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================
  // analog output channels
  dq_dac_chan u_dac1 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_low  (wr & (idx == `DQ_IDX_AO1L)),
    .wr_high (wr & (idx == `DQ_IDX_AO1H)),
    .wdata   (pwdata[7:0]),
    .code    (aout1_code)
  );

  dq_dac_chan u_dac2 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wr_low  (wr & (idx == `DQ_IDX_AO2L)),
    .wr_high (wr & (idx == `DQ_IDX_AO2H)),
    .wdata   (pwdata[7:0]),
    .code    (aout2_code)
  );

  // ==========================================
  // outputs
  assign prdata     = s_ff.apb.prdata;
  assign pready     = s_ff.apb.pready;
  assign pslverr    = s_ff.apb.pslverr;
  assign timer_req  = s_ff.tmr;
  assign adc_start  = s_ff.adc_start;
  assign irq        = s_ff.int_status;
  assign dma_req    = s_ff.dma_req;
  assign dout_lines = s_ff.dout;

  // ==========================================
  // checks
  property p_soft_start;
    @(posedge ref_clk) disable iff (!rst_n)
    soft_wr && soft_en && s_ff.conv_st == dq_pkg::DQ_ST_IDLE |=> adc_start;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("no soft start");

  property p_din_read;
    @(posedge ref_clk) disable iff (!rst_n)
    rd && idx == `DQ_IDX_AO2L |=> pready && prdata[7:0] == $past(din_lines[7:0]);
  endproperty
  a_din_read: assert property (p_din_read) else $error("input byte read wrong");

  property p_dout_write;
    @(posedge ref_clk) disable iff (!rst_n)
    wr && idx == `DQ_IDX_DOUTH |=> dout_lines[15:8] == $past(pwdata[7:0]);
  endproperty
  a_dout_write: assert property (p_dout_write) else $error("output high byte wrong");

  property p_dac_update;
    @(posedge ref_clk) disable iff (!rst_n)
    wr && idx == `DQ_IDX_AO1H |=> aout1_code[11:8] == $past(pwdata[3:0]);
  endproperty
  a_dac_update: assert property (p_dac_update) else $error("dac high nibble wrong");

  property p_conv_time;
    @(posedge ref_clk) disable iff (!rst_n)
    adc_start |-> !s_ff.done_flag ##0 (!s_ff.done_flag)[*1] ##[1:CONV_LIM] s_ff.done_flag;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion too long");

  property p_busy_ignore;
    @(posedge ref_clk) disable iff (!rst_n)
    s_ff.conv_st == dq_pkg::DQ_ST_CONV && !conv_end |=> !adc_start;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("restart while busy");

  property p_ext_only;
    @(posedge ref_clk) disable iff (!rst_n)
    trigger_source_jumper && !ext_edge |=> !adc_start;
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("internal trigger leaked");

  property p_flag_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    rd && idx == `DQ_IDX_ADL && !conv_end |=> !s_ff.done_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag kept after read");

  property p_irq_set;
    @(posedge ref_clk) disable iff (!rst_n)
    conv_end && s_ff.op_mode == `DQ_MODE_PINT |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq missing after conversion");

  property p_irq_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    irq && !(wr && idx == `DQ_IDX_INTCLR) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear");

  property p_dma_set;
    @(posedge ref_clk) disable iff (!rst_n)
    conv_end && s_ff.op_mode == `DQ_MODE_PDMA |=> dma_req;
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("dma request missing");

  // two sync stages then the edge flop: the pulse lines up with the end of the run
  property p_ext_sync;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(external_trigger_input) ##1 external_trigger_input[*2]
      |-> ext_edge;
  endproperty
  a_ext_sync: assert property (p_ext_sync) else $error("external edge lost");

  property p_mode_gate;
    @(posedge ref_clk) disable iff (!rst_n)
    s_ff.op_mode == `DQ_MODE_OFF && !trigger_source_jumper |=> !adc_start;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("start with triggers off");

  // a finishing conversion beats a consuming read in the same cycle
  property p_done_set;
    @(posedge ref_clk) disable iff (!rst_n)
    conv_end |=> s_ff.done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_pacer_start;
    @(posedge ref_clk) disable iff (!rst_n)
    pacer_en && pacer_edge && s_ff.conv_st == dq_pkg::DQ_ST_IDLE |=> adc_start;
  endproperty
  a_pacer_start: assert property (p_pacer_start) else $error("no pacer start");

  property p_dma_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    dma_req && !dma_ack |=> dma_req;
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("dma request dropped");

  c_soft_conv: cover property (@(posedge ref_clk) disable iff (!rst_n)
    soft_wr && soft_en ##[1:CONV_LIM] conv_end);
  c_irq_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
    irq ##1 (wr && idx == `DQ_IDX_INTCLR));
  c_ext_conv: cover property (@(posedge ref_clk) disable iff (!rst_n)
    trigger_source_jumper && ext_edge ##1 adc_start);
  c_slverr: cover property (@(posedge ref_clk) disable iff (!rst_n) pslverr);
endmodule

// ==== src/dq_defines.svh ====
`ifndef DQ_DEFINES_SVH
`define DQ_DEFINES_SVH
// Functional notes
// - any write to software trigger index 12 starts a conversion in software mode.
// - digital inputs 0-7 read at index 6, 8-15 at index 7.
// - digital outputs 0-7 written at index 13, 8-15 at index 14.
// - analog out 1 code: low byte index 4, high nibble index 5.
// - analog out 2 written at indices 6 and 7; reads there return inputs.
// - analog code is 12 bits, low byte bit 0 is lsb.
// - low byte is held; output updates only when high byte is written.
// - indices 0-2 reach the three counters, index 3 the control byte.
// - cascaded counters 1 and 2 give the pacer trigger; counter 0 free.
// - done flag shows not-ready while converting, ready when finished.
// - reading the result low byte clears the done flag.
// - a conversion completes within 8 us of its trigger.
// - with external source selected, each rising edge starts a conversion.
// - with external source selected, software and pacer triggers are ignored.
// - internal trigger choice and transfer method come from mode index 11.
// - interrupt mode raises the interrupt when a result is ready.
// - dma mode requests a transfer of each finished result.
// - external trigger works with any transfer; pacer with dma or interrupt.
// - mode 000 off, 001 software/polled (reset), 010 pacer/dma, 110 pacer/int.
// - interrupt status set per conversion; any write to index 8 clears it.

// ==========================================
// register indices, byte address is four times the index
`define DQ_IDX_CNT0     6'h00
`define DQ_IDX_TCTL     6'h03
`define DQ_IDX_AO1L     6'h04
`define DQ_IDX_AO1H     6'h05
`define DQ_IDX_AO2L     6'h06
`define DQ_IDX_AO2H     6'h07
`define DQ_IDX_INTCLR   6'h08
`define DQ_IDX_OPMODE   6'h0B
`define DQ_IDX_SOFT     6'h0C
`define DQ_IDX_DOUTL    6'h0D
`define DQ_IDX_DOUTH    6'h0E
`define DQ_IDX_ADL      6'h10
`define DQ_IDX_ADH      6'h11

// ==========================================
// operation modes and fields
`define DQ_MODE_OFF     3'h0
`define DQ_MODE_SOFT    3'h1
`define DQ_MODE_PDMA    3'h2
`define DQ_MODE_PINT    3'h6
`define DQ_MODE_RST     3'h1
`define DQ_ADH_FLAG_BIT 4
`define DQ_DAC_HI_MSB   3
`define DQ_DAC_RST      12'h000

// ==========================================
// timing
`define DQ_CLK_NS       10
`define DQ_CONV_NS      8000
`define DQ_CONV_CYC     10'(`DQ_CONV_NS / `DQ_CLK_NS)
`endif

// ==== src/dq_pkg.sv ====
package dq_pkg;
  // ==========================================
  // conversion sequencer states
  typedef enum logic [1:0] {
    DQ_ST_IDLE = 2'h0,
    DQ_ST_CONV = 2'h1
  } dq_conv_st_t;

  // request towards the interval timer
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] idx;
    logic [7:0] wdata;
  } dq_tmr_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dq_apb_rsp_t;

  typedef struct packed {
    logic [7:0]  low_ff;
    logic [11:0] code_ff;
  } dq_dac_state_t;

  typedef struct packed {
    dq_apb_rsp_t apb;
    logic        tmr_wait;
    dq_tmr_req_t tmr;
    logic [2:0]  op_mode;
    logic [15:0] dout;
    logic        ext_sync1;
    logic        ext_sync2;
    logic        ext_prev;
    logic        pacer_prev;
    dq_conv_st_t conv_st;
    logic [9:0]  conv_cnt;
    logic        adc_start;
    logic [11:0] adc_result;
    logic        done_flag;
    logic        int_status;
    logic        dma_req;
  } dq_state_t;
endpackage

// ==== src/dq_dac_chan.sv ====
`timescale 1ns/1ps
`include "dq_defines.svh"
module dq_dac_chan (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  output logic [11:0]      code
);
  dq_pkg::dq_dac_state_t s_ff;
  dq_pkg::dq_dac_state_t nxt_s;

  // ==========================================
  // double buffer: low byte waits for the high byte
  always_comb begin
    nxt_s = s_ff;
    if (wr_low) begin
      nxt_s.low_ff = wdata;
    end
    if (wr_high) begin
      // upper nibble of the high byte is ignored
      nxt_s.code_ff = {wdata[`DQ_DAC_HI_MSB:0], s_ff.low_ff};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign code = s_ff.code_ff;

  // ==========================================
  // checks
  property p_dac_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    !wr_high |=> $stable(code);
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("dac code moved early");
endmodule

// ==== verif/dq_far_model.sv ====
`timescale 1ns/1ps
// ==========================================
// far side: interval timer registers, pacer output and converter data
module dq_far_model (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire dq_pkg::dq_tmr_req_t timer_req,
  input  wire logic                pacer_en,
  input  wire logic                adc_start,
  output logic                     pacer_out,
  output logic [7:0]               timer_rdata,
  output logic [11:0]              adc_data
);
  logic [7:0] regs [4];
  logic [7:0] hold_ff;
  logic       hold_v;
  logic [9:0] pace;

  // read data stands while rd and one cycle after, otherwise it shows a stale inverse
  assign timer_rdata = timer_req.rd ? regs[timer_req.idx]
                     : (hold_v ? hold_ff : ~hold_ff);

  // timer byte store, slow pacer so that each pulse gives exactly one result
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff   <= 8'h00;
      hold_v    <= 1'b0;
      pace      <= 10'h000;
      pacer_out <= 1'b0;
      adc_data  <= 12'h000;
    end else begin
      if (timer_req.wr) regs[timer_req.idx] <= timer_req.wdata;
      hold_v <= timer_req.rd;
      if (timer_req.rd) hold_ff <= regs[timer_req.idx];
      pace <= (!pacer_en || pace == 10'h3E7) ? 10'h000 : pace + 10'h001;
      pacer_out <= pacer_en && pace == 10'h3E7;
      if (adc_start) adc_data <= 12'($urandom);
    end
  end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`include "dq_defines.svh"
module tb;
  logic                ref_clk, rst_n, psel, penable, pwrite, jmp, ext, pacer_en, dma_ack;
  logic [7:0]          paddr, timer_rdata, lo, hi;
  logic [31:0]         pwdata, prdata, r;
  logic                pready, pslverr, pacer_out, adc_start, irq, dma_req, e;
  logic [11:0]         adc_data, ao1, ao2;
  logic [11:0]         exp_ao [2];
  logic [15:0]         din, dout;
  dq_pkg::dq_tmr_req_t timer_req;
  int                  n_errors, checks, cyc;

  // ==========================================
  // clock, instances, timeout
  always #5 ref_clk = ~ref_clk;

  dq_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_source_jumper(jmp), .external_trigger_input(ext),
    .pacer_out(pacer_out), .timer_rdata(timer_rdata), .timer_req(timer_req),
    .adc_start(adc_start), .adc_data(adc_data), .irq(irq), .dma_req(dma_req),
    .dma_ack(dma_ack), .din_lines(din), .dout_lines(dout), .aout1_code(ao1),
    .aout2_code(ao2));

  dq_far_model far (.ref_clk(ref_clk), .rst_n(rst_n), .timer_req(timer_req),
    .pacer_en(pacer_en), .adc_start(adc_start), .pacer_out(pacer_out),
    .timer_rdata(timer_rdata), .adc_data(adc_data));

  // a hang would otherwise run forever
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      n_errors++;
      $display("Error %0t: timeout", $time);
      stop_test();
    end
  end

  // ==========================================
  // tasks
  task stop_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // expected converter code: upper nibble of the high byte is ignored
  function automatic logic [11:0] dac_exp(input logic [7:0] l, input logic [7:0] h);
    return {h[3:0], l};
  endfunction

  // one transfer; the idle edge first keeps psel from being driven twice in a step
  task apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'($urandom), d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("Error %0t: no pready", $time);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait, then check the done flag, the result and the clear by low-byte read
  task conv(input int w, input logic done);
    logic [3:0] rh;
    repeat (w) @(posedge ref_clk);
    apb(1'b0, `DQ_IDX_ADH, 8'h00);
    chk(r[`DQ_ADH_FLAG_BIT], done);
    rh = r[3:0];
    apb(1'b0, `DQ_IDX_ADL, 8'h00);
    if (done) chk({rh, r[7:0]}, adc_data);
    apb(1'b0, `DQ_IDX_ADH, 8'h00);
    chk(r[`DQ_ADH_FLAG_BIT], 1'b0);
  endtask

  task wait_for(input logic use_dma);
    int n;
    n = 0;
    while ((use_dma ? dma_req : irq) !== 1'b1 && n < 2100) begin
      @(posedge ref_clk);
      n++;
    end
    // a request that never comes is a mismatch, not a silent fall-through
    if (n >= 2100) begin
      n_errors++;
      $display("Error %0t: no transfer request", $time);
    end
  endtask

  // ==========================================
  // main sequence
  initial begin
    {ref_clk, rst_n, psel, penable, pwrite, jmp, ext, pacer_en, dma_ack} = '0;
    paddr = '0;
    pwdata = '0;
    din = '0;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    exp_ao = '{12'h000, 12'h000};
    r = $urandom(32'h20CA3BE6);
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({dout, irq, dma_req}, 32'h0);
    chk({ao1, ao2}, 32'h0);
    $display("test reset done");
    // low byte alone must not move the output; both channels, twice each
    for (int k = 0; k < 4; k++) begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      apb(1'b1, `DQ_IDX_AO1L + 6'(2 * (k % 2)), lo);
      chk((k % 2) ? ao2 : ao1, exp_ao[k % 2]);
      apb(1'b1, `DQ_IDX_AO1H + 6'(2 * (k % 2)), hi);
      exp_ao[k % 2] = dac_exp(lo, hi);
      chk((k % 2) ? ao2 : ao1, exp_ao[k % 2]);
    end
    $display("test dac done");
    din <= 16'($urandom);
    apb(1'b0, `DQ_IDX_AO2L, 8'h00);
    chk(r, {24'h0, din[7:0]});
    apb(1'b0, `DQ_IDX_AO2H, 8'h00);
    chk(r, {24'h0, din[15:8]});
    lo = 8'($urandom);
    hi = 8'($urandom);
    apb(1'b1, `DQ_IDX_DOUTL, lo);
    apb(1'b1, `DQ_IDX_DOUTH, hi);
    chk(dout, {hi, lo});
    apb(1'b0, `DQ_IDX_DOUTL, 8'h00);
    chk(r, 32'h0);
    apb(1'b1, `DQ_IDX_CNT0, lo);
    apb(1'b1, `DQ_IDX_TCTL, hi);
    apb(1'b0, `DQ_IDX_CNT0, 8'h00);
    chk(r, {24'h0, lo});
    apb(1'b0, `DQ_IDX_TCTL, 8'h00);
    chk(r, {24'h0, hi});
    apb(1'b1, 6'h3F, 8'h00);
    chk(e, 1'b1);
    $display("test dio timer done");
    // reset mode is software trigger; a second trigger mid-conversion is dropped
    apb(1'b1, `DQ_IDX_SOFT, 8'($urandom));
    apb(1'b0, `DQ_IDX_ADH, 8'h00);
    chk(r[`DQ_ADH_FLAG_BIT], 1'b0);
    repeat (400) @(posedge ref_clk);
    apb(1'b1, `DQ_IDX_SOFT, 8'($urandom));
    conv(420, 1'b1);
    conv(0, 1'b0);
    apb(1'b1, `DQ_IDX_OPMODE, 8'(`DQ_MODE_OFF));
    apb(1'b1, `DQ_IDX_SOFT, 8'($urandom));
    conv(815, 1'b0);
    apb(1'b1, `DQ_IDX_OPMODE, 8'(`DQ_MODE_SOFT));
    jmp <= 1'b1;
    apb(1'b1, `DQ_IDX_SOFT, 8'($urandom));
    conv(815, 1'b0);
    ext <= 1'b1;
    conv(815, 1'b1);
    ext <= 1'b0;
    $display("test trigger done");
    jmp <= 1'b0;
    apb(1'b1, `DQ_IDX_OPMODE, 8'(`DQ_MODE_PINT));
    pacer_en <= 1'b1;
    wait_for(1'b0);
    chk({irq, dma_req}, 2'b10);
    pacer_en <= 1'b0;
    conv(0, 1'b1);
    chk(irq, 1'b1);
    apb(1'b1, `DQ_IDX_INTCLR, 8'($urandom));
    chk(irq, 1'b0);
    apb(1'b1, `DQ_IDX_OPMODE, 8'(`DQ_MODE_PDMA));
    pacer_en <= 1'b1;
    wait_for(1'b1);
    chk({irq, dma_req}, 2'b01);
    pacer_en <= 1'b0;
    conv(0, 1'b1);
    dma_ack <= 1'b1;
    @(posedge ref_clk);
    dma_ack <= 1'b0;
    @(posedge ref_clk);
    chk(dma_req, 1'b0);
    $display("test transfer done");
    stop_test();
  end
endmodule
